/* timer_pkg.sv */
// Purpose: Shared constants and register layouts of the free-running capture/compare timer.
// Assumes: APB byte addresses, one 32-bit word per register, 16-bit data in the low bits.
// Notes:   Every offset, reset value and field layout used by the timer lives here.
package timer_pkg;

    // ==================================================================
    // Register byte addresses
    localparam logic [7:0] CONTROL_STATUS_ADDR = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_ADDR  = 8'h04;
    localparam logic [7:0] OUTPUT_CONTROL_ADDR = 8'h08;
    localparam logic [7:0] COUNTER_ADDR        = 8'h0c;
    localparam logic [7:0] COMPARE_ADDR        = 8'h10;
    localparam logic [7:0] CAPTURE_A_ADDR      = 8'h14;
    localparam logic [7:0] CAPTURE_B_ADDR      = 8'h18;
    localparam logic [7:0] CAPTURE_C_ADDR      = 8'h1c;
    localparam logic [7:0] CAPTURE_D_ADDR      = 8'h20;

    // ==================================================================
    // Reset values and counter maximum
    localparam logic [15:0] COUNTER_RESET  = 16'h0000;
    localparam logic [15:0] COMPARE_RESET  = 16'hfffe;
    localparam logic [15:0] CAPTURE_RESET  = 16'h0000;
    localparam logic [15:0] INTERVAL_RESET = 16'hffff;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam logic [15:0] COUNTER_MAX    = 16'hffff;

    // ==================================================================
    // Count clock selection and prescaler masks
    localparam logic [1:0] CLOCK_DIV2     = 2'h0;
    localparam logic [1:0] CLOCK_DIV8     = 2'h1;
    localparam logic [1:0] CLOCK_DIV32    = 2'h2;
    localparam logic [1:0] CLOCK_EXTERNAL = 2'h3;
    localparam logic [4:0] PRESCALE_DIV2  = 5'h01;
    localparam logic [4:0] PRESCALE_DIV8  = 5'h07;
    localparam logic [4:0] PRESCALE_DIV32 = 5'h1f;

    // ==================================================================
    // Capture channel indices and pin vector positions
    localparam int CAP_A   = 0;
    localparam int CAP_B   = 1;
    localparam int CAP_C   = 2;
    localparam int CAP_D   = 3;
    localparam int EXT_PIN = 4;

    // ==================================================================
    // Register layouts, most significant field first
    typedef struct packed {
        logic captureAFlag;
        logic captureBFlag;
        logic captureCFlag;
        logic captureDFlag;
        logic compareAFlag;
        logic compareBFlag;
        logic overflowFlag;
        logic clearOnMatchA;
    } control_status_t;

    typedef struct packed {
        logic       edgeSelectA;
        logic       edgeSelectB;
        logic       edgeSelectC;
        logic       edgeSelectD;
        logic       bufferAEnable;
        logic       bufferBEnable;
        logic [1:0] clockSelect;
    } timer_control_t;

    typedef struct packed {
        logic captureMaskMode;
        logic autoAddMode;
        logic captureSelect;
        logic compareSelect;
        logic outputAEnable;
        logic outputBEnable;
        logic outputALevel;
        logic outputBLevel;
    } output_control_t;

    localparam control_status_t STATUS_RESET = '0;
    localparam timer_control_t  TCTRL_RESET  = '0;
    localparam output_control_t OCTRL_RESET  = '0;

endpackage : timer_pkg

/* free_running_timer_unit.sv */
// Purpose: 16-bit free-running timer with two compare outputs, four capture inputs and APB registers.
// Assumes: core_clk at 25 MHz; capture and count pins are asynchronous and pass two flip-flops.
// Notes:   The rules carried by this block are listed below, each with its tag.
`timescale 1ns/1ps

module free_running_timer_unit (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic        externalCountIn,
    input  wire logic        captureInA,
    input  wire logic        captureInB,
    input  wire logic        captureInC,
    input  wire logic        captureInD,
    output logic             waveOutA,
    output logic             waveOutB
);

    // ==================================================================
    // Register state
    timer_pkg::control_status_t status;
    timer_pkg::timer_control_t  tctrl;
    timer_pkg::output_control_t octrl;
    logic [15:0] counterValue;
    logic [15:0] compareAValue;
    logic [15:0] compareBValue;
    logic [15:0] captureValue [4];
    logic [15:0] riseInterval;
    logic [15:0] fallInterval;
    logic [7:0]  captureMaskInterval;
    logic [15:0] maskEnd;
    logic        maskActive;
    logic        nextAddFall;
    logic        lastAddFall;
    logic [4:0]  prescale;
    logic [4:0]  pinMeta;
    logic [4:0]  pinSync;
    logic [4:0]  pinPrev;

    // ==================================================================
    // APB decode
    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = (addr == timer_pkg::CONTROL_STATUS_ADDR) || (addr == timer_pkg::TIMER_CONTROL_ADDR) ||
                   (addr == timer_pkg::OUTPUT_CONTROL_ADDR) || (addr == timer_pkg::COUNTER_ADDR) ||
                   (addr == timer_pkg::COMPARE_ADDR) || (addr == timer_pkg::CAPTURE_A_ADDR) ||
                   (addr == timer_pkg::CAPTURE_B_ADDR) || (addr == timer_pkg::CAPTURE_C_ADDR) ||
                   (addr == timer_pkg::CAPTURE_D_ADDR);
    endfunction : isMapped

    logic writeStrobe;
    assign writeStrobe = psel && penable && pready && pwrite && isMapped(paddr);

    function automatic logic writesTo(input logic [7:0] target);
        writesTo = writeStrobe && (paddr == target);
    endfunction : writesTo

    logic wrCompareA;
    logic wrCompareB;
    logic wrRise;
    logic wrFall;
    logic wrMask;
    assign wrCompareA = writesTo(timer_pkg::COMPARE_ADDR) && !octrl.compareSelect;
    assign wrCompareB = writesTo(timer_pkg::COMPARE_ADDR) && octrl.compareSelect;
    assign wrRise     = writesTo(timer_pkg::CAPTURE_A_ADDR) && !octrl.captureSelect;
    assign wrFall     = writesTo(timer_pkg::CAPTURE_B_ADDR) && !octrl.captureSelect;
    assign wrMask     = writesTo(timer_pkg::CAPTURE_C_ADDR) && !octrl.captureSelect;

    logic [31:0] readValue;
    always_comb begin
        readValue = 32'h0000_0000;
        case (paddr)
            timer_pkg::CONTROL_STATUS_ADDR: readValue[7:0]  = status;
            timer_pkg::TIMER_CONTROL_ADDR:  readValue[7:0]  = tctrl;
            timer_pkg::OUTPUT_CONTROL_ADDR: readValue[7:0]  = octrl;
            timer_pkg::COUNTER_ADDR:        readValue[15:0] = counterValue;
            timer_pkg::COMPARE_ADDR:        readValue[15:0] = octrl.compareSelect ? compareBValue : compareAValue;
            timer_pkg::CAPTURE_A_ADDR:      readValue[15:0] = octrl.captureSelect ? captureValue[timer_pkg::CAP_A]
                                                                                  : riseInterval;
            timer_pkg::CAPTURE_B_ADDR:      readValue[15:0] = octrl.captureSelect ? captureValue[timer_pkg::CAP_B]
                                                                                  : fallInterval;
            timer_pkg::CAPTURE_C_ADDR:      readValue[15:0] = octrl.captureSelect ? captureValue[timer_pkg::CAP_C]
                                                                                  : {8'h00, captureMaskInterval};
            timer_pkg::CAPTURE_D_ADDR:      readValue[15:0] = captureValue[timer_pkg::CAP_D];
            default:                        readValue       = 32'h0000_0000;
        endcase
    end

    // Read data is sampled in the setup cycle and presented throughout the access cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !isMapped(paddr);
            prdata  <= (psel && !penable && !pwrite) ? readValue : 32'h0000_0000;
        end
    end

    // ==================================================================
    // Pin synchronisers and edge detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 5'h00;
            pinSync <= 5'h00;
            pinPrev <= 5'h00;
        end else begin
            pinMeta <= {externalCountIn, captureInD, captureInC, captureInB, captureInA};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    logic [3:0] edgeSelect;
    logic [3:0] captureEdge;
    assign edgeSelect = {tctrl.edgeSelectD, tctrl.edgeSelectC, tctrl.edgeSelectB, tctrl.edgeSelectA};

    // Edge select: 1 picks rising, 0 picks falling.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            assign captureEdge[gi] = edgeSelect[gi] ? (pinSync[gi] && !pinPrev[gi])
                                                    : (!pinSync[gi] && pinPrev[gi]);
        end
    endgenerate

    // ==================================================================
    // Count clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 5'h00;
        end else begin
            prescale <= prescale + 5'h01;
        end
    end

    logic countTick;
    always_comb begin
        case (tctrl.clockSelect)
            timer_pkg::CLOCK_DIV2:  countTick = (prescale & timer_pkg::PRESCALE_DIV2) == timer_pkg::PRESCALE_DIV2;
            timer_pkg::CLOCK_DIV8:  countTick = (prescale & timer_pkg::PRESCALE_DIV8) == timer_pkg::PRESCALE_DIV8;
            timer_pkg::CLOCK_DIV32: countTick = prescale == timer_pkg::PRESCALE_DIV32;
            default:                countTick = pinSync[timer_pkg::EXT_PIN] && !pinPrev[timer_pkg::EXT_PIN];
        endcase
    end

    // Match is taken in the count period in which the counter equals the compare value.
    logic matchA;
    logic matchB;
    logic wrCounter;
    assign matchA    = countTick && (counterValue == compareAValue);
    assign matchB    = countTick && (counterValue == compareBValue);
    assign wrCounter = writesTo(timer_pkg::COUNTER_ADDR);

    // Counter with clear on match A.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            counterValue <= timer_pkg::COUNTER_RESET;
        end else if (wrCounter) begin
            counterValue <= pwdata[15:0];
        end else if (countTick) begin
            counterValue <= (matchA && status.clearOnMatchA) ? timer_pkg::COUNTER_RESET : counterValue + 16'h0001;
        end
    end

    logic overflowEvent;
    assign overflowEvent = countTick && !wrCounter && (counterValue == timer_pkg::COUNTER_MAX) &&
                           !(matchA && status.clearOnMatchA);

    // ==================================================================
    // Control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tctrl <= timer_pkg::TCTRL_RESET;
        end else if (writesTo(timer_pkg::TIMER_CONTROL_ADDR)) begin
            tctrl <= pwdata[7:0];
        end
    end

    logic autoAddStart;
    assign autoAddStart = writesTo(timer_pkg::OUTPUT_CONTROL_ADDR) && pwdata[6] && !octrl.autoAddMode;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            octrl <= timer_pkg::OCTRL_RESET;
        end else if (writesTo(timer_pkg::OUTPUT_CONTROL_ADDR)) begin
            octrl <= pwdata[7:0];
        end
    end

    // ==================================================================
    // Compare registers and auto-add
    logic [15:0] addend;
    logic        autoMatch;
    assign addend    = nextAddFall ? fallInterval : riseInterval;
    assign autoMatch = matchA && octrl.autoAddMode;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            compareAValue <= timer_pkg::COMPARE_RESET;
            compareBValue <= timer_pkg::COMPARE_RESET;
        end else begin
            if (wrCompareA) begin
                compareAValue <= pwdata[15:0];
            end else if (autoMatch) begin
                compareAValue <= compareAValue + addend;
            end
            if (wrCompareB) begin
                compareBValue <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nextAddFall <= 1'b1;
            lastAddFall <= 1'b0;
        end else if (autoAddStart) begin
            nextAddFall <= 1'b1;
            lastAddFall <= 1'b0;
        end else if (autoMatch) begin
            nextAddFall <= !nextAddFall;
            lastAddFall <= nextAddFall;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            riseInterval <= timer_pkg::INTERVAL_RESET;
            fallInterval <= timer_pkg::INTERVAL_RESET;
        end else begin
            if (wrRise) begin
                riseInterval <= pwdata[15:0];
            end
            if (wrFall) begin
                fallInterval <= pwdata[15:0];
            end
        end
    end

    // Pins low from reset until a match drives them.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            waveOutA <= 1'b0;
            waveOutB <= 1'b0;
        end else begin
            if (matchA && octrl.outputAEnable) begin
                waveOutA <= octrl.autoAddMode ? lastAddFall : octrl.outputALevel;
            end
            if (matchB && octrl.outputBEnable) begin
                waveOutB <= octrl.outputBLevel;
            end
        end
    end

    // ==================================================================
    // Capture channels
    logic [3:0] captureTake;
    // A buffered channel's own pin is ignored.
    assign captureTake = {captureEdge[timer_pkg::CAP_D] && !tctrl.bufferBEnable && !maskActive,
                          captureEdge[timer_pkg::CAP_C] && !tctrl.bufferAEnable,
                          captureEdge[timer_pkg::CAP_B],
                          captureEdge[timer_pkg::CAP_A]};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                captureValue[i] <= timer_pkg::CAPTURE_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (captureTake[i]) begin
                    captureValue[i] <= counterValue;
                end
            end
            if (captureTake[timer_pkg::CAP_A] && tctrl.bufferAEnable) begin
                captureValue[timer_pkg::CAP_C] <= captureValue[timer_pkg::CAP_A];
            end
            if (captureTake[timer_pkg::CAP_B] && tctrl.bufferBEnable) begin
                captureValue[timer_pkg::CAP_D] <= captureValue[timer_pkg::CAP_B];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            captureMaskInterval <= timer_pkg::MASK_RESET;
        end else if (wrMask) begin
            captureMaskInterval <= pwdata[7:0];
        end
    end

    // Mask window, ends when the counter reaches capture plus twice the mask.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            maskActive <= 1'b0;
            maskEnd    <= timer_pkg::CAPTURE_RESET;
        end else if (captureTake[timer_pkg::CAP_D]) begin
            maskActive <= octrl.captureMaskMode && (captureMaskInterval != timer_pkg::MASK_RESET);
            maskEnd    <= counterValue + {7'h00, captureMaskInterval, 1'b0};
        end else if (maskActive && counterValue == maskEnd) begin
            maskActive <= 1'b0;
        end
    end

    // ==================================================================
    // Status flags: writing 0 clears a flag, a same-cycle event wins.
    logic [6:0] flagSet;
    logic [6:0] flagClear;
    // Capture flags sit A first from bit 7 down, the reverse of the channel index order.
    assign flagSet   = {captureTake[timer_pkg::CAP_A], captureTake[timer_pkg::CAP_B],
                        captureTake[timer_pkg::CAP_C], captureTake[timer_pkg::CAP_D],
                        matchA, matchB, overflowEvent};
    assign flagClear = writesTo(timer_pkg::CONTROL_STATUS_ADDR) ? ~pwdata[7:1] : 7'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= timer_pkg::STATUS_RESET;
        end else begin
            // Overflow flag; compare flags; capture flags.
            status[7:1] <= flagSet | (status[7:1] & ~flagClear);
            if (writesTo(timer_pkg::CONTROL_STATUS_ADDR)) begin
                status.clearOnMatchA <= pwdata[0];
            end
        end
    end

    // ==================================================================
    // Assertions
    a_overflow_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        overflowEvent |=> status.overflowFlag && counterValue == timer_pkg::COUNTER_RESET)
        else $error("Overflow did not wrap to zero with flag set.");

    a_match_clears_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        matchA && status.clearOnMatchA && !wrCounter |=> counterValue == timer_pkg::COUNTER_RESET)
        else $error("Counter not cleared on compare match A.");

    a_compare_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        matchA |=> status.compareAFlag)
        else $error("Compare A flag not set on match.");

    a_wave_b_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        matchB && octrl.outputBEnable |=> waveOutB == $past(octrl.outputBLevel))
        else $error("Wave B does not follow its level bit.");

    a_capture_copies_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        captureTake[timer_pkg::CAP_A] |=> captureValue[timer_pkg::CAP_A] == $past(counterValue))
        else $error("Capture A did not take the counter.");

    a_buffer_passes_old: assert property (@(posedge core_clk) disable iff (!rst_n)
        captureTake[timer_pkg::CAP_A] && tctrl.bufferAEnable
        |=> captureValue[timer_pkg::CAP_C] == $past(captureValue[timer_pkg::CAP_A]))
        else $error("Buffer C did not receive old capture A.");

    a_auto_add_sum: assert property (@(posedge core_clk) disable iff (!rst_n)
        autoMatch && !wrCompareA |=> compareAValue == $past(compareAValue) + $past(addend))
        else $error("Compare A not advanced by interval.");

    a_auto_first_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        autoAddStart |=> nextAddFall && !lastAddFall)
        else $error("Auto-add did not start with fall interval.");

    a_mask_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrMask |=> readValue[15:8] == 8'h00 || paddr != timer_pkg::CAPTURE_C_ADDR)
        else $error("Mask register upper byte not zero.");

    a_mask_blocks_d: assert property (@(posedge core_clk) disable iff (!rst_n)
        maskActive && captureEdge[timer_pkg::CAP_D] && !tctrl.bufferBEnable && !captureTake[timer_pkg::CAP_B]
        |=> $stable(captureValue[timer_pkg::CAP_D]))
        else $error("Capture D taken inside mask window.");

    a_mask_zero_none: assert property (@(posedge core_clk) disable iff (!rst_n)
        captureTake[timer_pkg::CAP_D] && captureMaskInterval == timer_pkg::MASK_RESET |=> !maskActive)
        else $error("Mask window opened with zero mask.");

endmodule : free_running_timer_unit

/* timer_pin_model.sv */
// Purpose: Pin-side partner of the timer, driving capture and count pins.
// Assumes: One request bit per pin, in pin vector order of the package.
// Notes:   Pulses last three clocks; idle pins rest low.
`timescale 1ns/1ps
module timer_pin_model (
    // Clock and requests
    input  wire logic       core_clk,
    input  wire logic [4:0] pulseReq,
    // Pins
    output logic      [4:0] pins
);
    logic [1:0] hold [5] = '{default: 2'h0};
    // ==========
    // Pulse width kept.
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 5; i++) begin
            if (pulseReq[i]) hold[i] <= 2'h3;
            else if (hold[i] != 2'h0) hold[i] <= hold[i] - 2'h1;
        end
    end
    always_comb for (int i = 0; i < 5; i++) pins[i] = (hold[i] != 2'h0);
endmodule : timer_pin_model

/* test_free_running_timer_unit.sv */
// Purpose: Self-checking bench of the free-running timer unit.
// Assumes: Reads are checked from a queue of notes by a monitor.
// Notes:   External count clock keeps the counter still between pulses.
`timescale 1ns/1ps
module test_free_running_timer_unit;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, waveOutA, waveOutB;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h3a3d;
    logic [4:0] pulseReq = 5'h00, pins;
    logic [15:0] v;
    logic [32:0] expQ [$];
    int fail_count = 0, samples_checked = 0;
    free_running_timer_unit dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .externalCountIn(pins[timer_pkg::EXT_PIN]), .captureInA(pins[timer_pkg::CAP_A]),
        .captureInB(pins[1]), .captureInC(pins[2]), .captureInD(pins[3]), .waveOutA, .waveOutB);
    timer_pin_model pm (.core_clk, .pulseReq, .pins);
    initial forever #20 core_clk = ~core_clk;
    // ==========
    task check(input string n, input logic [32:0] s, input logic [32:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // Let one edge pass so a released psel is never raised again in the same time step.
        @(posedge core_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin fail_count++; give_verdict(); end
        psel <= 0; penable <= 0;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [15:0] d); xfer(1, a, {16'h0, d}); endtask : wr
    task rd(input logic [7:0] a, input logic [32:0] e); expQ.push_back(e); xfer(0, a, 0); endtask : rd
    task pulse(input int i); pulseReq[i] <= 1; @(posedge core_clk); pulseReq <= 0; repeat (6) @(posedge core_clk);
    endtask : pulse
    always @(posedge core_clk) if (psel && penable && pready && !pwrite) check("read", {pslverr, prdata}, expQ.pop_front());
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        check("waveOutA", waveOutA, 0);
        rd(8'h10, 33'hfffe);
        wr(8'h08, 16'h30);
        rd(8'h10, 33'hfffe);
        for (int i = 0; i < 4; i++) rd(8'h14 + 8'(4 * i), 33'h0);
        wr(8'h08, 16'h00);
        rd(8'h14, 33'hffff);
        rd(8'h18, 33'hffff);
        wr(8'h1c, 16'hff12);
        rd(8'h1c, 33'h12);
        rd(8'h24, 33'h1_0000_0000);
        $display("reset values done");
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; v = seed[15:0];
        wr(8'h04, 16'hfb);
        wr(8'h0c, v);
        pulse(0);
        wr(8'h0c, v ^ 16'h00ff);
        pulse(0);
        wr(8'h08, 16'h20);
        rd(8'h14, {17'h0, v ^ 16'h00ff});
        rd(8'h1c, {17'h0, v});
        rd(8'h00, 33'h80);
        $display("capture done");
        wr(8'h00, 16'h00);
        wr(8'h0c, 16'hffff);
        pulse(4);
        rd(8'h0c, 33'h0);
        rd(8'h00, 33'h02);
        $display("overflow done");
        wr(8'h08, 16'h0a);
        wr(8'h10, 16'h5);
        wr(8'h0c, 16'h5);
        wr(8'h00, 16'h00);
        pulse(4);
        check("waveOutA", waveOutA, 1);
        rd(8'h00, 33'h08);
        $display("compare done");
        // External count and intervals above one.
        wr(8'h14, 16'h3);
        wr(8'h18, 16'h2);
        wr(8'h08, 16'h48);
        wr(8'h0c, 16'h5);
        pulse(4);
        check("waveOutA", waveOutA, 0);
        rd(8'h10, 33'h7);
        pulse(4);
        pulse(4);
        check("waveOutA", waveOutA, 1);
        rd(8'h10, 33'ha);
        $display("auto add done");
        give_verdict();
    end
endmodule : test_free_running_timer_unit
